/* rtl/ees_pkg.sv */
// shared constants and types of the two-wire eeprom slave front end
// assumes one 200 MHz system clock and a synchronous active-low reset
package ees_pkg;

  // ****************************************
  // widths and counts
  // ****************************************
  localparam int ADDR_W = 17;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam logic [3:0] BIT_ZERO = 4'h0;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  // synchroniser reset: clock and data as released high, straps and protect as pulled low
  localparam logic [4:0] SYNC_RST = 5'h18;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [ADDR_W-1:0] ADDR_RST = 17'h0_0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  // device-type code of the address word; the value is arbitrary
  localparam logic [3:0] DEV_TYPE_DFLT = 4'h6;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_DEV = 3'b001,
    ST_AHI = 3'b011,
    ST_ALO = 3'b010,
    ST_WDAT = 3'b110,
    ST_RDAT = 3'b111,
    ST_WAIT = 3'b101
  } ees_state_e;

  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [BYTE_W-1:0] data;
  } ees_wr_s;

endpackage

/* rtl/ees_front.sv */
// two-wire slave front end of a page-organised eeprom, plus its write fifo
// assumes the array and its programming timer sit outside on i_sys_clk
`timescale 1ns/1ps

// ****************************************
// write fifo
// ****************************************
module ees_fifo #(
  parameter int WIDTH = 25,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [PW:0] cnt_ff;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (cnt_ff != CNT_FULL);
  assign o_out_valid = (cnt_ff != '0);
  assign o_out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge i_sys_clk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= i_in_data;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= (wr_ptr_ff == PTR_LAST) ? '0 : wr_ptr_ff + 1'b1;
      if (pop)
        rd_ptr_ff <= (rd_ptr_ff == PTR_LAST) ? '0 : rd_ptr_ff + 1'b1;
      case ({push, pop})
        2'b10: cnt_ff <= cnt_ff + 1'b1;
        2'b01: cnt_ff <= cnt_ff - 1'b1;
        default: cnt_ff <= cnt_ff;
      endcase
    end
  end
endmodule

// ****************************************
// slave front end
// ****************************************
module ees_front #(
  parameter logic [3:0] DEV_TYPE = ees_pkg::DEV_TYPE_DFLT
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  // serial bus pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // straps and protection
  input wire logic i_addr_strap_low,
  input wire logic i_addr_strap_high,
  input wire logic i_wp,
  // write stream to the array
  output logic o_wr_valid,
  input wire logic i_wr_ready,
  output ees_pkg::ees_wr_s o_wr,
  // read port of the array
  output logic o_rd_req,
  output logic [ees_pkg::ADDR_W-1:0] o_rd_addr,
  input wire logic i_rd_valid,
  input wire logic [ees_pkg::BYTE_W-1:0] i_rd_data,
  // programming and power state
  output logic o_prog_start,
  input wire logic i_prog_done,
  output logic o_busy,
  output logic o_standby
);
  import ees_pkg::*;

  logic [4:0] sync1_ff;
  logic [4:0] sync2_ff;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_s;
  logic sda_s;
  logic strap_lo_s;
  logic strap_hi_s;
  logic wp_s;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  ees_state_e st_ff;
  logic [3:0] cnt_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [BYTE_W-1:0] rd_byte_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic rw_ff;
  logic wrote_ff;
  logic sda_oe_ff;
  logic sda_o_ff;
  logic push_ff;
  ees_wr_s wr_ff;
  logic rd_req_ff;
  logic prog_start_ff;
  logic rd_stop_ff;
  logic nomatch_ff;
  logic busy_ff;
  logic standby_ff;
  logic fifo_ready;
  logic dev_match;

  // ****************************************
  // pin synchronisers and bus events
  // ****************************************
  // straps and protect pin are pulled low off-chip when floating
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      // idle-high history keeps a false clock or data edge out of the first cycles
      sync1_ff <= SYNC_RST;
      sync2_ff <= SYNC_RST;
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end
    else
    begin
      sync1_ff <= {i_scl, i_sda, i_addr_strap_low, i_addr_strap_high, i_wp};
      sync2_ff <= sync1_ff;
      scl_d_ff <= sync2_ff[4];
      sda_d_ff <= sync2_ff[3];
    end
  end

  assign scl_s = sync2_ff[4];
  assign sda_s = sync2_ff[3];
  assign strap_lo_s = sync2_ff[2];
  assign strap_hi_s = sync2_ff[1];
  assign wp_s = sync2_ff[0];
  assign scl_rise = scl_s && !scl_d_ff;
  assign scl_fall = !scl_s && scl_d_ff;
  // a data edge while the clock stays high is a framing event
  assign start_evt = scl_s && scl_d_ff && sda_d_ff && !sda_s;
  assign stop_evt = scl_s && scl_d_ff && !sda_d_ff && sda_s;
  assign dev_match = !busy_ff && (shift_ff[7:4] == DEV_TYPE)
    && (shift_ff[3:2] == {strap_hi_s, strap_lo_s});

  // ****************************************
  // protocol engine
  // ****************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_ff <= ST_IDLE;
      cnt_ff <= BIT_ZERO;
      shift_ff <= BYTE_RST;
      addr_ff <= ADDR_RST;
      rw_ff <= 1'b0;
      wrote_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
      push_ff <= 1'b0;
      wr_ff <= '0;
      rd_req_ff <= 1'b0;
      prog_start_ff <= 1'b0;
      rd_stop_ff <= 1'b0;
      nomatch_ff <= 1'b0;
    end
    else
    begin
      push_ff <= 1'b0;
      rd_req_ff <= 1'b0;
      prog_start_ff <= 1'b0;
      rd_stop_ff <= 1'b0;
      nomatch_ff <= 1'b0;
      if (start_evt)
      begin
        // a start always resynchronises, which also covers bus recovery
        st_ff <= ST_DEV;
        cnt_ff <= BIT_ZERO;
        sda_oe_ff <= 1'b0;
        wrote_ff <= 1'b0;
      end
      else if (stop_evt)
      begin
        st_ff <= ST_IDLE;
        cnt_ff <= BIT_ZERO;
        sda_oe_ff <= 1'b0;
        prog_start_ff <= wrote_ff;
        rd_stop_ff <= rw_ff && (st_ff == ST_RDAT || st_ff == ST_WAIT);
        wrote_ff <= 1'b0;
      end
      else if (st_ff != ST_IDLE && st_ff != ST_WAIT)
      begin
        if (scl_rise && cnt_ff < BIT_ACK)
        begin
          cnt_ff <= cnt_ff + 1'b1;
          if (st_ff != ST_RDAT)
            shift_ff <= {shift_ff[6:0], sda_s};
        end
        else if (scl_rise && cnt_ff == BIT_ACK && st_ff == ST_RDAT)
        begin
          // counter moves past the byte whether or not the master acks
          addr_ff <= addr_ff + 1'b1;
          cnt_ff <= BIT_DONE;
          if (sda_s)
            st_ff <= ST_WAIT;
          else
            rd_req_ff <= 1'b1;
        end
        else if (scl_fall && cnt_ff == BIT_ACK && st_ff != ST_RDAT)
        begin
          cnt_ff <= BIT_DONE;
          case (st_ff)
            ST_DEV:
            begin
              if (dev_match)
              begin
                sda_oe_ff <= 1'b1;
                rw_ff <= shift_ff[0];
                if (shift_ff[0])
                begin
                  st_ff <= ST_RDAT;
                  rd_req_ff <= 1'b1;
                end
                else
                begin
                  addr_ff[ADDR_W-1] <= shift_ff[1];
                  st_ff <= ST_AHI;
                end
              end
              else
              begin
                st_ff <= ST_IDLE;
                nomatch_ff <= 1'b1;
              end
            end
            ST_AHI:
            begin
              addr_ff[15:8] <= shift_ff;
              sda_oe_ff <= 1'b1;
              st_ff <= ST_ALO;
            end
            ST_ALO:
            begin
              addr_ff[7:0] <= shift_ff;
              sda_oe_ff <= 1'b1;
              st_ff <= ST_WDAT;
            end
            ST_WDAT:
            begin
              // a full fifo is refused by a nack instead of losing the byte
              if (!wp_s && fifo_ready)
              begin
                sda_oe_ff <= 1'b1;
                push_ff <= 1'b1;
                wr_ff <= '{addr: addr_ff, data: shift_ff};
                addr_ff[7:0] <= addr_ff[7:0] + 1'b1;
                wrote_ff <= 1'b1;
              end
              else
                st_ff <= ST_WAIT;
            end
            default: st_ff <= ST_IDLE;
          endcase
        end
        else if (scl_fall && cnt_ff == BIT_DONE)
        begin
          cnt_ff <= BIT_ZERO;
          if (st_ff == ST_RDAT)
          begin
            shift_ff <= rd_byte_ff;
            sda_oe_ff <= !rd_byte_ff[7];
          end
          else
            sda_oe_ff <= 1'b0;
        end
        else if (scl_fall && st_ff == ST_RDAT && cnt_ff != BIT_ZERO)
        begin
          shift_ff <= {shift_ff[6:0], 1'b0};
          sda_oe_ff <= (cnt_ff == BIT_ACK) ? 1'b0 : !shift_ff[6];
        end
      end
    end
  end

  // ****************************************
  // read data, power state, open-drain level
  // ****************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
      rd_byte_ff <= BYTE_RST;
    else if (i_rd_valid)
      rd_byte_ff <= i_rd_data;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      busy_ff <= 1'b0;
      standby_ff <= 1'b1;
      sda_o_ff <= 1'b0;
    end
    else
    begin
      sda_o_ff <= 1'b0;
      busy_ff <= prog_start_ff || (busy_ff && !i_prog_done);
      if (rd_stop_ff || nomatch_ff || (busy_ff && i_prog_done))
        standby_ff <= 1'b1;
      else if (start_evt)
        standby_ff <= 1'b0;
    end
  end

  ees_fifo #(
    .WIDTH($bits(ees_wr_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_ff),
    .o_in_ready(fifo_ready),
    .i_in_data(wr_ff),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(o_wr)
  );

  assign o_sda_o = sda_o_ff;
  assign o_sda_oe = sda_oe_ff;
  assign o_rd_req = rd_req_ff;
  assign o_rd_addr = addr_ff;
  assign o_prog_start = prog_start_ff;
  assign o_busy = busy_ff;
  assign o_standby = standby_ff;

  // ****************************************
  // assertions
  // ****************************************
  sequence s_byte_end;
    scl_fall && cnt_ff == BIT_ACK && !start_evt && !stop_evt;
  endsequence

  sequence s_dev_end;
    s_byte_end ##0 st_ff == ST_DEV;
  endsequence

  property p_open_drain;
    @(posedge i_sys_clk) disable iff (!i_rst_n) !o_sda_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data line driven high");

  property p_oe_on_fall;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      $changed(sda_oe_ff) |-> $past(scl_fall) || $past(start_evt) || $past(stop_evt);
  endproperty
  a_oe_on_fall: assert property (p_oe_on_fall) else $error("data changed off clock fall");

  property p_start_dev;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      start_evt |=> st_ff == ST_DEV && cnt_ff == BIT_ZERO && !sda_oe_ff;
  endproperty
  a_start_dev: assert property (p_start_dev) else $error("start not taken");

  property p_read_stop;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      stop_evt && rw_ff && (st_ff == ST_RDAT || st_ff == ST_WAIT)
      |=> st_ff == ST_IDLE ##1 standby_ff;
  endproperty
  a_read_stop: assert property (p_read_stop) else $error("no standby after read stop");

  property p_ack_hi;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_byte_end ##0 st_ff == ST_AHI |=> sda_oe_ff && cnt_ff == BIT_DONE && st_ff == ST_ALO;
  endproperty
  a_ack_hi: assert property (p_ack_hi) else $error("address byte not acked");

  property p_mismatch;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_dev_end ##0 shift_ff[3:2] != {strap_hi_s, strap_lo_s}
      |=> !sda_oe_ff && st_ff == ST_IDLE ##1 standby_ff;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("mismatch acked");

  property p_busy_nack;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_dev_end ##0 busy_ff |=> !sda_oe_ff [*2];
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("ack while programming");

  property p_wp_block;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      s_byte_end ##0 st_ff == ST_WDAT && wp_s |=> !push_ff && st_ff == ST_WAIT;
  endproperty
  a_wp_block: assert property (p_wp_block) else $error("write while protected");

  property p_page_wrap;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      push_ff |-> addr_ff[ADDR_W-1:8] == wr_ff.addr[ADDR_W-1:8]
        && addr_ff[7:0] == wr_ff.addr[7:0] + 8'h01;
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page address stepped wrongly");

  property p_read_nack;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      scl_rise && cnt_ff == BIT_ACK && st_ff == ST_RDAT && sda_s && !start_evt
      |=> st_ff == ST_WAIT && !sda_oe_ff && !rd_req_ff;
  endproperty
  a_read_nack: assert property (p_read_nack) else $error("nack not honoured");

endmodule

/* dv/ees_bus_master.sv */
// behavioural two-wire bus master that drives the serial pins of the front end
// assumes i_sda is the resolved wire and that a released line reads high
`timescale 1ns/1ps

module ees_bus_master (
  // clock
  input wire logic i_sys_clk,
  // serial bus
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ****************************************
  // timing
  // ****************************************
  // half of the 160 ns serial clock period, in system cycles
  localparam int HALF = 16;

  // the serial clock stands high between frames
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // ****************************************
  // bit and frame level
  // ****************************************
  // data moves a quarter into the low phase, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    tick(4);
    o_sda <= b;
    tick(HALF - 4);
    o_scl <= 1'b1;
    tick(HALF / 2);
    s = i_sda;
    tick(HALF / 2);
    o_scl <= 1'b0;
  endtask

  task automatic start_cond();
    tick(4);
    o_sda <= 1'b1;
    tick(HALF - 4);
    o_scl <= 1'b1;
    tick(HALF / 2);
    o_sda <= 1'b0;
    tick(HALF / 2);
    o_scl <= 1'b0;
  endtask

  task automatic stop_cond();
    tick(4);
    o_sda <= 1'b0;
    tick(HALF - 4);
    o_scl <= 1'b1;
    tick(HALF / 2);
    o_sda <= 1'b1;
    tick(HALF);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // a low bit in the ninth slot asks for the next byte
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(~mack, s);
  endtask

  task automatic recover();
    logic s;
    start_cond();
    repeat (9) bit_io(1'b1, s);
    start_cond();
    stop_cond();
  endtask
endmodule

/* dv/ees_front_tb_top.sv */
// self-checking bench of the eeprom slave front end with a simple array model
// assumes the package, the design files and the bus master model compile first
`timescale 1ns/1ps

`define CHK(act, exp) \
  begin \
    checks_done++; \
    if ((act) !== (exp)) \
    begin \
      fails++; \
      $display("[FAIL] t=%0t act=%h exp=%h", $time, (act), (exp)); \
    end \
  end

module ees_front_tb_top;
  import ees_pkg::*;

  // ****************************************
  // signals and instances
  // ****************************************
  localparam logic [3:0] DT = DEV_TYPE_DFLT;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl;
  logic mst_sda;
  logic sda;
  logic strap_lo = 1'b0;
  logic strap_hi = 1'b1;
  logic wp = 1'b0;
  logic wr_ready = 1'b1;
  logic prog_done = 1'b0;
  logic rd_valid = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic rd_pend = 1'b0;
  logic [ADDR_W-1:0] rd_a = 17'h0_0000;
  logic oe_q = 1'b0;
  logic sda_o, sda_oe, wr_valid, rd_req, prog_start, busy, standby;
  logic [ADDR_W-1:0] rd_addr;
  ees_wr_s wr;
  ees_wr_s wr_q[$];
  int fails = 0;
  int checks_done = 0;
  int prog_cnt = 0;

  // open-drain wire with a pull-up
  assign sda = mst_sda & ~sda_oe;

  initial
  begin
    forever #2.5 clk = ~clk;
  end

  ees_bus_master i_mst (
    .i_sys_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(mst_sda)
  );

  ees_front #(.DEV_TYPE(DT)) i_dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_addr_strap_low(strap_lo), .i_addr_strap_high(strap_hi), .i_wp(wp),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr(wr),
    .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_valid(rd_valid), .i_rd_data(rd_data),
    .o_prog_start(prog_start), .i_prog_done(prog_done), .o_busy(busy), .o_standby(standby)
  );

  // ****************************************
  // array model and line monitors
  // ****************************************
  function automatic logic [7:0] rd_fn(input logic [ADDR_W-1:0] a);
    return a[7:0] ^ {a[16], 7'h3c};
  endfunction

  function automatic logic [7:0] dev(input logic [1:0] st, input logic top, input logic rw);
    return {DT, st, top, rw};
  endfunction

  // reads answer two cycles after the request, well inside the allowed fourteen
  always @(posedge clk)
  begin
    oe_q <= sda_oe;
    rd_pend <= rd_req;
    rd_a <= rd_addr;
    rd_valid <= rd_pend;
    rd_data <= rd_fn(rd_a);
    if (rst_n && sda_oe !== oe_q)
      `CHK(scl, 1'b0)
    if (rst_n && sda_oe === 1'b1)
      `CHK(sda_o, 1'b0)
    if (rst_n && prog_start === 1'b1)
      prog_cnt <= prog_cnt + 1;
    if (rst_n && wr_valid === 1'b1 && wr_ready === 1'b1)
      wr_q.push_back(wr);
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic stop_test();
    if (fails == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic set_addr(input logic [ADDR_W-1:0] a);
    logic ack;
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, a[16], 1'b0), ack);
    `CHK(ack, 1'b1)
    i_mst.put_byte(a[15:8], ack);
    `CHK(ack, 1'b1)
    i_mst.put_byte(a[7:0], ack);
    `CHK(ack, 1'b1)
  endtask

  task automatic wait_drain();
    int n;
    n = 0;
    while (wr_valid !== 1'b0 && n < 50)
    begin
      tick(1);
      n++;
    end
    if (wr_valid !== 1'b0)
    begin
      fails++;
      stop_test();
    end
    tick(2);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK(standby, 1'b1)
    `CHK(sda_oe, 1'b0)
    `CHK(busy, 1'b0)
    `CHK(rd_addr, ADDR_RST)
  endtask

  // straps set to high=1, low=0; last pass carries a wrong type code
  task automatic t_strap();
    logic ack;
    for (int k = 0; k < 5; k++)
    begin
      i_mst.start_cond();
      i_mst.put_byte(k < 4 ? dev(2'(k), 1'b0, 1'b0) : {~DT, 4'h8}, ack);
      `CHK(ack, k == 2)
      i_mst.stop_cond();
      `CHK(standby, k != 2)
    end
  endtask

  // fifo filled with the array stalled, fifth byte refused, page wrap
  task automatic t_write();
    logic ack;
    ees_wr_s exp;
    wr_ready <= 1'b0;
    set_addr(17'h1_12ff);
    for (int i = 0; i < 5; i++)
    begin
      i_mst.put_byte(8'hc0 + 8'(i), ack);
      `CHK(ack, i < FIFO_DEPTH)
    end
    i_mst.stop_cond();
    `CHK(prog_cnt, 1)
    `CHK(busy, 1'b1)
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, 1'b0, 1'b0), ack);
    `CHK(ack, 1'b0)
    i_mst.stop_cond();
    wr_ready <= 1'b1;
    wait_drain();
    `CHK(wr_q.size(), FIFO_DEPTH)
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      exp.addr = {9'h112, 8'hff + 8'(i)};
      exp.data = 8'hc0 + 8'(i);
      `CHK(wr_q[i], exp)
    end
    wr_q.delete();
    // a start clears standby, so only the finished program can set it again
    i_mst.start_cond();
    `CHK(standby, 1'b0)
    prog_done <= 1'b1;
    tick(1);
    prog_done <= 1'b0;
    tick(3);
    `CHK(busy, 1'b0)
    `CHK(standby, 1'b1)
    i_mst.stop_cond();
  endtask

  task automatic t_wp();
    logic ack;
    wp <= 1'b1;
    set_addr(17'h0_0010);
    i_mst.put_byte(8'h55, ack);
    `CHK(ack, 1'b0)
    i_mst.stop_cond();
    tick(4);
    `CHK(prog_cnt, 1)
    `CHK(wr_q.size(), 0)
    wp <= 1'b0;
  endtask

  // random read across the array end, then a current-address read
  task automatic t_read();
    logic ack;
    logic [7:0] b;
    logic [ADDR_W-1:0] a;
    set_addr(17'h1_fffe);
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, 1'b0, 1'b1), ack);
    `CHK(ack, 1'b1)
    a = 17'h1_fffe;
    for (int i = 0; i < 3; i++)
    begin
      i_mst.get_byte(i < 2, b);
      `CHK(b, rd_fn(a))
      a = a + 17'h0_0001;
    end
    i_mst.stop_cond();
    `CHK(standby, 1'b1)
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, 1'b1, 1'b1), ack);
    `CHK(ack, 1'b1)
    i_mst.get_byte(1'b0, b);
    `CHK(b, rd_fn(a))
    i_mst.stop_cond();
  endtask

  // read cut off while the device is shifting a byte out
  task automatic t_recover();
    logic ack, s;
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, 1'b0, 1'b1), ack);
    repeat (3) i_mst.bit_io(1'b1, s);
    i_mst.recover();
    `CHK(sda_oe, 1'b0)
    i_mst.start_cond();
    i_mst.put_byte(dev(2'b10, 1'b0, 1'b0), ack);
    `CHK(ack, 1'b1)
    i_mst.stop_cond();
  endtask

  initial
  begin
    tick(8);
    rst_n <= 1'b1;
    tick(4);
    t_reset();
    t_strap();
    t_write();
    t_wp();
    t_read();
    t_recover();
    stop_test();
  end
endmodule
